/* File: idrd_defines.svh */
// offsets, field positions, codes and reset values of the irq/dma descriptor framer
`ifndef IDRD_DEFINES_SVH
`define IDRD_DEFINES_SVH

// ****************************************************
// register byte addresses
// ****************************************************
`define IDRD_A_CTRL 8'h00
`define IDRD_A_IRQ0 8'h04
`define IDRD_A_IRQ1 8'h08
`define IDRD_A_DMA0 8'h0C
`define IDRD_A_DMA1 8'h10
`define IDRD_A_STREAM 8'h14
`define IDRD_A_STATUS 8'h18

// ****************************************************
// reset values
// ****************************************************
`define IDRD_CTRL_RST 4'h0
`define IDRD_IRQ_RST 21'h00_0000
`define IDRD_DMA_RST 15'h0000

// ****************************************************
// irq config word fields
// ****************************************************
`define IDRD_IRQ_W 21
`define IDRD_IRQ_INFO_BIT 20
`define IDRD_IRQ_CAP_HI 19
`define IDRD_IRQ_CAP_LO 17

// ****************************************************
// dma config word fields
// ****************************************************
`define IDRD_DMA_W 15
`define IDRD_DMA_SPD_HI 14
`define IDRD_DMA_SPD_LO 13
`define IDRD_DMA_WORD_BIT 12
`define IDRD_DMA_BYTE_BIT 11
`define IDRD_DMA_MSTR_BIT 10
`define IDRD_DMA_SIZE_HI 9
`define IDRD_DMA_SIZE_LO 8

// ****************************************************
// item tags, lengths and legal masks
// ****************************************************
`define IDRD_IRQ_TAG_SHORT 8'h22
`define IDRD_IRQ_TAG_LONG 8'h23
`define IDRD_DMA_TAG 8'h2A
`define IDRD_IRQ_LEN_SHORT 3'h3
`define IDRD_IRQ_LEN_LONG 3'h4
`define IDRD_DMA_LEN 3'h3
`define IDRD_IRQ_VALID 16'hDEF8
`define IDRD_DMA_VALID 8'hEF
`define IDRD_SIZE_RSVD 2'h3
`define IDRD_SIZE_BOTH 2'h1

`endif

/* File: idrd_pkg.sv */
// types shared by the descriptor framer modules
package idrd_pkg;

  typedef logic [7:0] idrd_addr_t;
  typedef logic [7:0] idrd_byte_t;

  // gray along the emission order
  typedef enum logic [2:0] {
    IT_IRQ0 = 3'b000,
    IT_IRQ1 = 3'b001,
    IT_DMA0 = 3'b011,
    IT_DMA1 = 3'b010,
    IT_DONE = 3'b110
  } idrd_item_t;

endpackage : idrd_pkg

/* File: idrd_item_if.sv */
// carrier between the sequencer and one item encoder
`timescale 1ns/10ps
`default_nettype none

interface idrd_item_if (
  input wire logic clk,
  input wire logic nrst
);
  logic [31:0] cfg;
  logic [1:0] idx;
  logic [7:0] data;
  logic [2:0] len;

  modport enc (input clk, input nrst, input cfg, input idx, output data, output len);
  modport seq (output cfg, output idx, input data, input len);
endinterface : idrd_item_if

`default_nettype wire

/* File: idrd_irq_enc.sv */
// byte encoder for one interrupt item
`timescale 1ns/10ps
`default_nettype none
`include "idrd_defines.svh"

module idrd_irq_enc (
  idrd_item_if.enc it
);
  import idrd_pkg::*;

  logic info;
  logic [15:0] mask;

  assign info = it.cfg[`IDRD_IRQ_INFO_BIT];
  // levels missing from the connector never leave the card
  assign mask = it.cfg[15:0] & `IDRD_IRQ_VALID;

  always_comb begin
    it.len = info ? `IDRD_IRQ_LEN_LONG : `IDRD_IRQ_LEN_SHORT;
    unique case (it.idx)
      2'd0: it.data = info ? `IDRD_IRQ_TAG_LONG : `IDRD_IRQ_TAG_SHORT;
      2'd1: it.data = mask[7:0];
      2'd2: it.data = mask[15:8];
      // edge-high forced on, top nibble zero
      2'd3: it.data = {4'h0, it.cfg[`IDRD_IRQ_CAP_HI:`IDRD_IRQ_CAP_LO], 1'b1};
    endcase
  end

  // ****************************************************
  // checks
  // ****************************************************
  property p_irq_info_low;
    @(posedge it.clk) disable iff (!it.nrst)
      (it.idx == 2'd3) |-> (it.data[7:4] == 4'h0 && it.data[0]);
  endproperty
  a_irq_info_low: assert property (p_irq_info_low) else $error("irq info byte malformed");

endmodule : idrd_irq_enc

`default_nettype wire

/* File: idrd_dma_enc.sv */
// byte encoder for one dma item
`timescale 1ns/10ps
`default_nettype none
`include "idrd_defines.svh"

module idrd_dma_enc (
  idrd_item_if.enc it
);
  import idrd_pkg::*;

  logic [1:0] size;

  // reserved size code is folded onto the mixed-width code
  assign size = (it.cfg[`IDRD_DMA_SIZE_HI:`IDRD_DMA_SIZE_LO] == `IDRD_SIZE_RSVD) ?
                `IDRD_SIZE_BOTH : it.cfg[`IDRD_DMA_SIZE_HI:`IDRD_DMA_SIZE_LO];

  always_comb begin
    it.len = `IDRD_DMA_LEN;
    unique case (it.idx)
      2'd0: it.data = `IDRD_DMA_TAG;
      2'd1: it.data = it.cfg[7:0] & `IDRD_DMA_VALID;
      2'd2: it.data = {1'b0,
                       it.cfg[`IDRD_DMA_SPD_HI:`IDRD_DMA_SPD_LO],
                       it.cfg[`IDRD_DMA_WORD_BIT],
                       it.cfg[`IDRD_DMA_BYTE_BIT],
                       it.cfg[`IDRD_DMA_MSTR_BIT],
                       size};
      2'd3: it.data = 8'h00;
    endcase
  end

  // ****************************************************
  // checks
  // ****************************************************
  property p_dma_size;
    @(posedge it.clk) disable iff (!it.nrst)
      (it.idx == 2'd2) |-> (it.data[1:0] != 2'b11 && !it.data[7]);
  endproperty
  a_dma_size: assert property (p_dma_size) else $error("dma reserved code emitted");

endmodule : idrd_dma_enc

`default_nettype wire

/* File: idrd_framer.sv */
// irq/dma resource item framer: config registers and byte stream sequencer
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "idrd_defines.svh"

// What this block does
// - irq item tag is 0x22, or 0x23 with the information byte.
// - irq mask low byte is levels 0-7, high byte levels 8-15.
// - irq mask is two bytes, covering all sixteen levels; set means implemented.
// - one irq item per needed level, never combined; the block sends the mask as written, so an item may list several levels.
// - absent information byte means edge-triggered active-high only.
// - info bits 3..0: low level, high level, low edge, high edge.
// - info bits 7..4 always read zero.
// - with info present, the high-edge bit is always set.
// - only levels present on the connector may be set.
// - dma item tag is 0x2A with two data bytes.
// - first dma byte is the channel mask, bit n for channel n.
// - one dma item per needed channel; the block sends the channel mask as written, so an item may list several.
// - dma byte two bits 6..5 give channel speed.
// - dma byte two bit 4 flags count-by-word.
// - dma byte two flags count-by-byte.
// - dma byte two flags bus master.
module idrd_framer (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire idrd_pkg::idrd_addr_t addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic done_o
);
  import idrd_pkg::*;

  // ****************************************************
  // item order helpers
  // ****************************************************
  function automatic idrd_item_t next_item(idrd_item_t it);
    unique case (it)
      IT_IRQ0: next_item = IT_IRQ1;
      IT_IRQ1: next_item = IT_DMA0;
      IT_DMA0: next_item = IT_DMA1;
      default: next_item = IT_DONE;
    endcase
  endfunction : next_item

  function automatic logic item_en(idrd_item_t it, logic [3:0] en);
    unique case (it)
      IT_IRQ0: item_en = en[0];
      IT_IRQ1: item_en = en[1];
      IT_DMA0: item_en = en[2];
      IT_DMA1: item_en = en[3];
      default: item_en = 1'b1;
    endcase
  endfunction : item_en

  // disabled slots are skipped without costing a read
  function automatic idrd_item_t first_en(idrd_item_t it, logic [3:0] en);
    idrd_item_t r;
    r = it;
    for (int i = 0; i < 4; i++) begin
      if (r != IT_DONE && !item_en(r, en)) begin
        r = next_item(r);
      end
    end
    return r;
  endfunction : first_en

  // ****************************************************
  // state
  // ****************************************************
  logic [3:0] ctrl_q;
  logic [`IDRD_IRQ_W-1:0] irq_cfg_q [2];
  logic [`IDRD_DMA_W-1:0] dma_cfg_q [2];
  idrd_item_t item_q;
  logic [1:0] pos_q;
  logic [31:0] rdata_q;
  logic done_q;

  idrd_item_t cur;
  logic is_dma;
  logic [7:0] sel_data;
  logic [2:0] sel_len;
  logic last_byte;
  logic rd_stream;
  logic restart;

  assign cur = first_en(item_q, ctrl_q);
  assign is_dma = (cur == IT_DMA0) || (cur == IT_DMA1);

  // ****************************************************
  // encoders
  // ****************************************************
  idrd_item_if irq_if (.clk(clk_i), .nrst(nrst_i));
  idrd_item_if dma_if (.clk(clk_i), .nrst(nrst_i));

  assign irq_if.cfg = {11'h000, irq_cfg_q[cur == IT_IRQ1]};
  assign irq_if.idx = pos_q;
  assign dma_if.cfg = {17'h0_0000, dma_cfg_q[cur == IT_DMA1]};
  assign dma_if.idx = pos_q;

  idrd_irq_enc u_irq (.it(irq_if.enc));
  idrd_dma_enc u_dma (.it(dma_if.enc));

  assign sel_data = is_dma ? dma_if.data : irq_if.data;
  assign sel_len = is_dma ? dma_if.len : irq_if.len;
  assign last_byte = ({1'b0, pos_q} == sel_len - 3'd1);

  // ****************************************************
  // bus decode
  // ****************************************************
  assign rd_stream = rd_i && (addr_i == `IDRD_A_STREAM) && (cur != IT_DONE);
  // a status write restarts the stream, as card reset does
  assign restart = wr_i && (addr_i == `IDRD_A_STATUS);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= `IDRD_CTRL_RST;
    end else if (wr_i && addr_i == `IDRD_A_CTRL) begin
      ctrl_q <= wdata_i[3:0];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_cfg_q[0] <= `IDRD_IRQ_RST;
      irq_cfg_q[1] <= `IDRD_IRQ_RST;
    end else if (wr_i && addr_i == `IDRD_A_IRQ0) begin
      irq_cfg_q[0] <= wdata_i[`IDRD_IRQ_W-1:0];
    end else if (wr_i && addr_i == `IDRD_A_IRQ1) begin
      irq_cfg_q[1] <= wdata_i[`IDRD_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dma_cfg_q[0] <= `IDRD_DMA_RST;
      dma_cfg_q[1] <= `IDRD_DMA_RST;
    end else if (wr_i && addr_i == `IDRD_A_DMA0) begin
      dma_cfg_q[0] <= wdata_i[`IDRD_DMA_W-1:0];
    end else if (wr_i && addr_i == `IDRD_A_DMA1) begin
      dma_cfg_q[1] <= wdata_i[`IDRD_DMA_W-1:0];
    end
  end

  // ****************************************************
  // stream sequencer
  // ****************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      item_q <= IT_IRQ0;
      pos_q <= 2'd0;
    end else if (restart) begin
      item_q <= IT_IRQ0;
      pos_q <= 2'd0;
    end else if (rd_stream) begin
      if (last_byte) begin
        item_q <= next_item(cur);
        pos_q <= 2'd0;
      end else begin
        item_q <= cur;
        pos_q <= pos_q + 2'd1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (cur == IT_DONE);
    end
  end

  // ****************************************************
  // read data, one cycle after the strobe only
  // ****************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (!rd_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      unique case (addr_i)
        `IDRD_A_CTRL: rdata_q <= {28'h000_0000, ctrl_q};
        `IDRD_A_IRQ0: rdata_q <= {11'h000, irq_cfg_q[0]};
        `IDRD_A_IRQ1: rdata_q <= {11'h000, irq_cfg_q[1]};
        `IDRD_A_DMA0: rdata_q <= {17'h0_0000, dma_cfg_q[0]};
        `IDRD_A_DMA1: rdata_q <= {17'h0_0000, dma_cfg_q[1]};
        // past the end: flag set, byte zero
        `IDRD_A_STREAM: rdata_q <= (cur == IT_DONE) ? 32'h0000_0100 :
                                   {24'h00_0000, sel_data};
        `IDRD_A_STATUS: rdata_q <= {26'h000_0000, cur == IT_DONE, cur, pos_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign rdata_o = rdata_q;
  assign done_o = done_q;

  // ****************************************************
  // checks
  // ****************************************************
  logic rd_irq;
  logic rd_dma;
  assign rd_irq = rd_stream && !is_dma;
  assign rd_dma = rd_stream && is_dma;

  property p_irq_tag;
    @(posedge clk_i) disable iff (!nrst_i)
      (rd_irq && pos_q == 2'd0) |=>
        (rdata_o[7:1] == 7'b0010001 && rdata_o[0] == $past(irq_if.cfg[`IDRD_IRQ_INFO_BIT]));
  endproperty
  a_irq_tag: assert property (p_irq_tag) else $error("irq tag wrong");

  property p_irq_lo;
    @(posedge clk_i) disable iff (!nrst_i)
      (rd_irq && pos_q == 2'd1) |=>
        (rdata_o[7:0] == ($past(irq_if.cfg[7:0]) & `IDRD_IRQ_VALID));
  endproperty
  a_irq_lo: assert property (p_irq_lo) else $error("irq low mask wrong");

  property p_irq_hi;
    @(posedge clk_i) disable iff (!nrst_i)
      (rd_irq && pos_q == 2'd2) |=>
        (rdata_o[7:0] == ($past(irq_if.cfg[15:8]) & 8'hDE) && !rdata_o[8]);
  endproperty
  a_irq_hi: assert property (p_irq_hi) else $error("irq high mask wrong");

  property p_irq_valid;
    @(posedge clk_i) disable iff (!nrst_i)
      (rd_irq && pos_q == 2'd1) |=> (rdata_o[2:0] == 3'b000);
  endproperty
  a_irq_valid: assert property (p_irq_valid) else $error("absent irq level set");

  property p_irq_info;
    @(posedge clk_i) disable iff (!nrst_i)
      (rd_irq && pos_q == 2'd3) |=>
        (rdata_o[7:0] == {4'h0, $past(irq_if.cfg[`IDRD_IRQ_CAP_HI:`IDRD_IRQ_CAP_LO]), 1'b1});
  endproperty
  a_irq_info: assert property (p_irq_info) else $error("irq info wrong");

  property p_info_rsvd;
    @(posedge clk_i) disable iff (!nrst_i)
      (rd_irq && pos_q == 2'd3) |=> (rdata_o[7:4] == 4'h0);
  endproperty
  a_info_rsvd: assert property (p_info_rsvd) else $error("info reserved set");

  property p_irq_short;
    @(posedge clk_i) disable iff (!nrst_i)
      (rd_irq && pos_q == 2'd2 && !irq_if.cfg[`IDRD_IRQ_INFO_BIT]) |=> (pos_q == 2'd0);
  endproperty
  a_irq_short: assert property (p_irq_short) else $error("short irq item overran");

  property p_dma_tag;
    @(posedge clk_i) disable iff (!nrst_i)
      (rd_dma && pos_q == 2'd0) |=> (rdata_o[7:0] == 8'h2A);
  endproperty
  a_dma_tag: assert property (p_dma_tag) else $error("dma tag wrong");

  property p_dma_mask;
    @(posedge clk_i) disable iff (!nrst_i)
      (rd_dma && pos_q == 2'd1) |=>
        (rdata_o[7:0] == ($past(dma_if.cfg[7:0]) & `IDRD_DMA_VALID));
  endproperty
  a_dma_mask: assert property (p_dma_mask) else $error("dma mask wrong");

  property p_dma_flags;
    @(posedge clk_i) disable iff (!nrst_i)
      (rd_dma && pos_q == 2'd2) |=>
        (rdata_o[6:2] == $past(dma_if.cfg[`IDRD_DMA_SPD_HI:`IDRD_DMA_MSTR_BIT]) && !rdata_o[7]);
  endproperty
  a_dma_flags: assert property (p_dma_flags) else $error("dma flags wrong");

  property p_dma_one;
    @(posedge clk_i) disable iff (!nrst_i)
      (rd_dma && pos_q == 2'd2) |=> (pos_q == 2'd0 && item_q == $past(next_item(cur)));
  endproperty
  a_dma_one: assert property (p_dma_one) else $error("dma item not closed");

  property p_irq_next;
    @(posedge clk_i) disable iff (!nrst_i)
      (rd_irq && last_byte && !restart) |=> (item_q != $past(cur) && pos_q == 2'd0);
  endproperty
  a_irq_next: assert property (p_irq_next) else $error("irq item not closed");

  property p_done_track;
    @(posedge clk_i) disable iff (!nrst_i)
      1'b1 |=> (done_o == $past(cur == IT_DONE));
  endproperty
  a_done_track: assert property (p_done_track) else $error("done flag out of step");

  property p_rd_idle;
    @(posedge clk_i) disable iff (!nrst_i)
      !rd_i |=> (rdata_o == 32'h0000_0000);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data held too long");

  c_irq_long: cover property (@(posedge clk_i) disable iff (!nrst_i)
    rd_irq && pos_q == 2'd3);
  c_dma_item: cover property (@(posedge clk_i) disable iff (!nrst_i)
    rd_dma && pos_q == 2'd2);
  c_done: cover property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && addr_i == `IDRD_A_STREAM && cur == IT_DONE);

endmodule : idrd_framer

`default_nettype wire

/* File: idrd_host.sv */
// host reader model driving the descriptor register port
`timescale 1ns/10ps
`default_nettype none

module idrd_host (
  input wire logic clk_i,
  output idrd_pkg::idrd_addr_t addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [31:0] rdata_i
);
  import idrd_pkg::*;

  initial begin
    addr_o = 8'h00;
    wdata_o = 32'h0000_0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // ****************************************************
  // bus cycles
  // ****************************************************
  task automatic wr(input idrd_addr_t a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    // stale data flipped so nothing leans on a held bus
    wdata_o <= ~d;
  endtask : wr

  task automatic rd(input idrd_addr_t a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    // data stand only in this cycle
    #1;
    d = rdata_i;
  endtask : rd
endmodule : idrd_host

`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the irq/dma descriptor framer
`timescale 1ns/10ps
`default_nettype none
`include "idrd_defines.svh"

module testbench;
  import idrd_pkg::*;

  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  idrd_addr_t addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wr;
  logic rd;
  logic done;
  int miscompares = 0;
  int n_compared = 0;
  logic [7:0] exp_q[$];

  always #10 clk_i = ~clk_i;

  idrd_framer idrd_framer_inst (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .addr_i(addr),
    .wdata_i(wdata),
    .wr_i(wr),
    .rd_i(rd),
    .rdata_o(rdata),
    .done_o(done)
  );

  idrd_host idrd_host_inst (
    .clk_i(clk_i),
    .addr_o(addr),
    .wdata_o(wdata),
    .wr_o(wr),
    .rd_o(rd),
    .rdata_i(rdata)
  );

  // ****************************************************
  // compare and verdict
  // ****************************************************
  task automatic give_verdict;
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic chk_word(input logic [31:0] e, input logic [31:0] g, input string m);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t %s got %h want %h", $time, m, g, e);
    end
  endtask : chk_word

  task automatic chk_flag(input logic e, input logic g, input string m);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t %s flag %b want %b", $time, m, g, e);
    end
  endtask : chk_flag

  // ****************************************************
  // expected item bytes
  // ****************************************************
  task automatic put_irq(input logic [31:0] c);
    exp_q.push_back(c[20] ? 8'h23 : 8'h22);
    exp_q.push_back(8'(c[7:0] & `IDRD_IRQ_VALID));
    exp_q.push_back(c[15:8] & 8'hDE);
    if (c[20]) begin
      exp_q.push_back({4'h0, c[19:17], 1'b1});
    end
  endtask : put_irq

  task automatic put_dma(input logic [31:0] c);
    logic [1:0] sz;
    sz = (c[9:8] == `IDRD_SIZE_RSVD) ? `IDRD_SIZE_BOTH : c[9:8];
    exp_q.push_back(8'h2A);
    exp_q.push_back(c[7:0] & `IDRD_DMA_VALID);
    exp_q.push_back({1'b0, c[14:10], sz});
  endtask : put_dma

  task automatic run_stream(input string m);
    logic [31:0] d;
    while (exp_q.size() > 0) begin
      idrd_host_inst.rd(`IDRD_A_STREAM, d);
      chk_word({24'h00_0000, exp_q.pop_front()}, d, m);
    end
    idrd_host_inst.rd(`IDRD_A_STREAM, d);
    chk_word(32'h0000_0100, d, m);
    chk_flag(1'b1, done, m);
  endtask : run_stream

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_reset;
    logic [31:0] d;
    chk_flag(1'b1, done, "done after reset");
    idrd_host_inst.rd(`IDRD_A_CTRL, d);
    chk_word(32'h0000_0000, d, "ctrl reset");
    idrd_host_inst.rd(`IDRD_A_IRQ0, d);
    chk_word(32'h0000_0000, d, "irq0 reset");
    idrd_host_inst.rd(`IDRD_A_DMA1, d);
    chk_word(32'h0000_0000, d, "dma1 reset");
    idrd_host_inst.rd(8'h1C, d);
    chk_word(32'h0000_0000, d, "unmapped");
    run_stream("empty stream");
  endtask : t_reset

  task automatic t_irq;
    logic [31:0] c0[2] = '{32'h0000_FFFF, 32'h0000_0107};
    logic [31:0] c1[2] = '{32'h001E_0028, 32'h0012_8000};
    logic [31:0] d;
    for (int i = 0; i < 2; i++) begin
      idrd_host_inst.wr(`IDRD_A_IRQ0, c0[i]);
      idrd_host_inst.wr(`IDRD_A_IRQ1, c1[i]);
      idrd_host_inst.wr(`IDRD_A_CTRL, 32'h0000_0003);
      idrd_host_inst.wr(`IDRD_A_STATUS, 32'h0000_0000);
      idrd_host_inst.rd(`IDRD_A_IRQ1, d);
      chk_word(c1[i], d, "irq1 readback");
      // read data must fall back to zero once its single cycle is over
      @(posedge clk_i);
      #1;
      chk_word(32'h0000_0000, rdata, "read data held");
      put_irq(c0[i]);
      put_irq(c1[i]);
      run_stream("irq items");
    end
  endtask : t_irq

  task automatic t_dma;
    logic [31:0] c0;
    logic [31:0] c1;
    for (int i = 0; i < 4; i++) begin
      c0 = 32'h0000_00FF | (32'(i) << 13) | (32'(i) << 8) | (32'(i & 1) << 12);
      c0 = c0 | (32'(i >> 1) << 11) | (32'(~i & 1) << 10);
      c1 = 32'h0000_0011 | (32'(3 - i) << 13) | (32'(3 - i) << 8) | (32'(~i & 1) << 12);
      c1 = c1 | (32'(~i >> 1 & 1) << 11) | (32'(i & 1) << 10);
      idrd_host_inst.wr(`IDRD_A_DMA0, c0);
      idrd_host_inst.wr(`IDRD_A_DMA1, c1);
      idrd_host_inst.wr(`IDRD_A_CTRL, 32'h0000_000C);
      idrd_host_inst.wr(`IDRD_A_STATUS, 32'h0000_0000);
      put_dma(c0);
      put_dma(c1);
      run_stream("dma items");
    end
  endtask : t_dma

  task automatic t_all;
    logic [31:0] d;
    idrd_host_inst.wr(`IDRD_A_IRQ0, 32'h0000_0008);
    idrd_host_inst.wr(`IDRD_A_IRQ1, 32'h0014_0400);
    idrd_host_inst.wr(`IDRD_A_DMA0, 32'h0000_5501);
    idrd_host_inst.wr(`IDRD_A_DMA1, 32'h0000_2A80);
    idrd_host_inst.wr(`IDRD_A_CTRL, 32'h0000_000F);
    idrd_host_inst.wr(`IDRD_A_STATUS, 32'h0000_0000);
    // abandon part way; restart must begin again at the first item
    repeat (5) idrd_host_inst.rd(`IDRD_A_STREAM, d);
    chk_flag(1'b0, done, "done mid stream");
    // three short irq0 bytes read, then two of irq1
    idrd_host_inst.rd(`IDRD_A_STATUS, d);
    chk_word({26'h000_0000, 1'b0, IT_IRQ1, 2'd2}, d, "status mid stream");
    idrd_host_inst.wr(`IDRD_A_STATUS, 32'h0000_0000);
    put_irq(32'h0000_0008);
    put_irq(32'h0014_0400);
    put_dma(32'h0000_5501);
    put_dma(32'h0000_2A80);
    run_stream("all items");
  endtask : t_all

  // ****************************************************
  // main sequence and watchdog
  // ****************************************************
  initial begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    // done is launched on the first edge after release; look one edge later
    repeat (2) @(posedge clk_i);
    t_reset();
    t_irq();
    t_dma();
    t_all();
    give_verdict();
  end

  initial begin
    #1000000;
    miscompares++;
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
